// >>> shared/sprb_pkg.sv
// constants for the stream put / reverse subtract / return from break unit
// assumes a 32-bit core with big-endian bit numbering mapped to [31:0]
`default_nettype none
package sprb_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int XLEN       = 32;
  localparam int LINK_MAX   = 16;
  localparam int LINK_IDX_W = 4;
  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_PUTD   = 6'h13;  // dynamic stream put
  localparam logic [5:0] OP_RTBD   = 6'h2D;  // return family major opcode
  localparam logic [4:0] RTBD_SEL  = 5'h12;  // return from break selector
  localparam logic [2:0] OP_RSUB   = 3'h0;   // register reverse subtract
  localparam logic [2:0] OP_RSUBI  = 3'h1;   // immediate reverse subtract
  localparam int BIT_PUT_ONE = 10;
  localparam int BIT_NBLK    = 9;
  localparam int BIT_CTRL    = 8;
  localparam int BIT_TEST    = 7;
  localparam int BIT_ATOM    = 6;
  localparam int BIT_KEEP    = 28;
  localparam int BIT_CUSE    = 27;
  localparam int BIT_SUBTAG  = 26;
  // ----------------------------------------------------------------
  // exception cause and register map
  // ----------------------------------------------------------------
  localparam logic [4:0] EC_PRIV    = 5'h07;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_EXC    = 4'h4;
  localparam int ST_CARRY = 0;
  localparam int ST_UM    = 1;
  localparam int ST_UMS   = 2;
  localparam int ST_VM    = 3;
  localparam int ST_VMS   = 4;
  localparam int ST_BIP   = 5;
  localparam int ST_W     = 6;
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [4:0] CAUSE_RST  = 5'h00;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_PUT, S_SLOT} sprb_state_t;
endpackage
`default_nettype wire

// >>> logic/sprb_exec.sv
// execution unit for dynamic stream put, reverse subtract and return from break
// assumes the pipeline holds instr_valid and operands stable while stall is high
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none

// Summary of operation
// - link index is low four bits of rB, link 0 if index not below count
// - blocking put stalls until the chosen link accepts a word
// - non-blocking put never waits; carry is 0 on accept, 1 on no space
// - last bit follows the control bit, data carries rA
// - test put behaves normally but never raises the valid strobe
// - atomic put shields the following instruction from interrupts
// - user-mode put with protection on raises privilege fault, link untouched
// - interrupts are served during a blocking stall unless atomic or in a delay slot
// - stream put exists only with links present and extended ops enabled
// - reverse subtract is rB plus inverted rA plus carry-in
// - keep bit leaves carry alone, otherwise carry takes adder carry-out
// - carry-use bit selects carry flag as carry-in, else constant one
// - carry after a subtraction means no borrow
// - immediate form uses extended immediate in place of rB
// - immediate is sign-extended unless a prefix supplies the upper half
// - return from break jumps to rA plus immediate and clears break flag
// - return from break runs one delay-slot instruction with breaks off
// - user-mode return from break raises privilege fault and does not branch
// - interrupts and breaks wait until delay slot and branch are done
module sprb_exec
  import sprb_pkg::*;
#(
  parameter int stream_link_count          = 16,
  parameter int mmu_level                  = 1,
  parameter int allow_user_stream_ops      = 0,
  parameter int extended_stream_ops_enable = 1
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset,
  // register port
  input  wire logic [3:0]                      reg_addr,
  input  wire logic [XLEN-1:0]                 reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [XLEN-1:0]                 reg_rdata,
  // instruction issue
  input  wire logic                            instr_valid,
  input  wire logic [XLEN-1:0]                 instr,
  input  wire logic [XLEN-1:0]                 op_a,
  input  wire logic [XLEN-1:0]                 op_b,
  input  wire logic                            imm_prefix_valid,
  input  wire logic [15:0]                     imm_prefix_hi,
  input  wire logic                            in_delay_slot,
  input  wire logic                            break_enter,
  output logic                                 stall,
  // results
  output logic                                 rd_write,
  output logic      [XLEN-1:0]                 rd_data,
  output logic                                 branch_valid,
  output logic      [XLEN-1:0]                 branch_target,
  output logic                                 exc_valid,
  output logic      [4:0]                      exc_cause,
  // interrupt and break gating
  input  wire logic                            irq_pending,
  output logic                                 irq_take,
  output logic                                 irq_allow,
  output logic                                 break_allow,
  // outgoing stream links
  output logic      [LINK_MAX-1:0][XLEN-1:0]   m_axis_tdata,
  output logic      [LINK_MAX-1:0]             m_axis_tlast,
  output logic      [LINK_MAX-1:0]             m_axis_tvalid,
  input  wire logic [LINK_MAX-1:0]             m_axis_tready
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  localparam bit PUT_PRESENT = (stream_link_count > 0) && (extended_stream_ops_enable == 1);
  localparam bit MMU_ON      = (mmu_level >= 1);
  localparam bit PUT_GUARDED = MMU_ON && (allow_user_stream_ops != 1);

  sprb_state_t           state_reg;
  logic [ST_W-1:0]       status_reg;
  logic [4:0]            cause_reg;
  logic                  atom_shadow_reg;
  logic [XLEN-1:0]       put_data_reg;
  logic                  put_last_reg;
  logic                  put_test_reg;
  logic                  put_nblk_reg;
  logic                  put_atom_reg;
  logic                  put_shield_reg;
  logic                  put_slot_reg;
  logic [LINK_IDX_W-1:0] put_link_reg;

  logic is_put, is_rsub, is_rtbd, accept, put_fault, rtb_fault;
  logic [XLEN-1:0] imm32, sub_b;
  logic [XLEN:0]   sub_sum;
  logic            sub_cin, sel_ready, put_done, put_abort;
  logic [LINK_IDX_W-1:0] link_sel;

  // the put decode vanishes when the option is off, so it falls through as a no-op
  assign is_put  = PUT_PRESENT && instr[31:26] == OP_PUTD && instr[BIT_PUT_ONE];
  assign is_rsub = (instr[31:29] == OP_RSUB || instr[31:29] == OP_RSUBI) && instr[BIT_SUBTAG];
  assign is_rtbd = instr[31:26] == OP_RTBD && instr[25:21] == RTBD_SEL;
  assign accept  = instr_valid && !stall;
  assign put_fault = PUT_GUARDED && status_reg[ST_UM];
  assign rtb_fault = MMU_ON && status_reg[ST_UM];

  // link index from rB, out-of-range folds to link 0
  assign link_sel = (int'(op_b[LINK_IDX_W-1:0]) >= stream_link_count) ?
                    '0 : op_b[LINK_IDX_W-1:0];

  // immediate operand: prefix supplies the upper half when present
  assign imm32 = imm_prefix_valid ? {imm_prefix_hi, instr[15:0]} :
                 {{16{instr[15]}}, instr[15:0]};

  // ----------------------------------------------------------------
  // reverse subtract datapath
  // ----------------------------------------------------------------
  // one adder: b + ~a + cin, carry-out is the no-borrow flag
  // a carry-in of one turns this into a plain two's complement subtraction
  assign sub_b   = (instr[31:29] == OP_RSUBI) ? imm32 : op_b;
  assign sub_cin = instr[BIT_CUSE] ? status_reg[ST_CARRY] : 1'b1;
  assign sub_sum = {1'b0, sub_b} + {1'b0, ~op_a} + {{XLEN{1'b0}}, sub_cin};

  // ----------------------------------------------------------------
  // stream handshake
  // ----------------------------------------------------------------
  assign sel_ready = m_axis_tready[put_link_reg];
  // test puts still wait for space, they just never strobe
  assign put_done  = (state_reg == S_PUT) && (sel_ready || put_nblk_reg);
  // a stalled blocking put yields to an interrupt unless shielded or in a delay slot
  assign put_abort = (state_reg == S_PUT) && !sel_ready && !put_nblk_reg && irq_pending &&
                     !put_shield_reg && !put_slot_reg;
  assign irq_take  = put_abort;
  assign stall     = (state_reg == S_PUT);

  // every link sees the same data flops; only the chosen one gets valid
  genvar gi;
  generate
    for (gi = 0; gi < LINK_MAX; gi++) begin : g_link
      assign m_axis_tdata[gi]  = put_data_reg;
      assign m_axis_tlast[gi]  = put_last_reg;
      assign m_axis_tvalid[gi] = (state_reg == S_PUT) && !put_test_reg &&
                                 (put_link_reg == LINK_IDX_W'(gi));
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt and break gating
  // ----------------------------------------------------------------
  // the slot state covers both the delay-slot instruction and the branch
  assign irq_allow   = (state_reg == S_IDLE) && !atom_shadow_reg && !in_delay_slot;
  assign break_allow = (state_reg == S_IDLE) && !status_reg[ST_BIP];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // idle -> put while a word is offered; idle -> slot after return from break
  // no default: every code that reset can reach is one of the three states
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (accept && is_put && !put_fault) begin
            state_reg <= S_PUT;
          end else if (accept && is_rtbd && !rtb_fault) begin
            state_reg <= S_SLOT;
          end
        end
        S_PUT: begin
          if (put_done || put_abort) begin
            state_reg <= S_IDLE;
          end
        end
        S_SLOT: begin
          if (accept && is_put && !put_fault) begin
            state_reg <= S_PUT;
          end else if (accept) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // put capture, taken only on a legal put so the link stays quiet on a fault
  // limitation: an abandoned put leaves these loaded; the re-issued put reloads them
  always_ff @(posedge clk) begin
    if (reset) begin
      put_data_reg   <= '0;
      put_last_reg   <= 1'b0;
      put_test_reg   <= 1'b0;
      put_nblk_reg   <= 1'b0;
      put_atom_reg   <= 1'b0;
      put_shield_reg <= 1'b0;
      put_slot_reg   <= 1'b0;
      put_link_reg   <= '0;
    end else if (accept && is_put && !put_fault) begin
      put_data_reg   <= op_a;
      put_last_reg   <= instr[BIT_CTRL];
      put_test_reg   <= instr[BIT_TEST];
      put_nblk_reg   <= instr[BIT_NBLK];
      put_atom_reg   <= instr[BIT_ATOM];
      put_shield_reg <= instr[BIT_ATOM] || atom_shadow_reg;
      put_slot_reg   <= in_delay_slot || state_reg == S_SLOT;
      put_link_reg   <= link_sel;
    end
  end

  // atomic shadow covers exactly the next instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      atom_shadow_reg <= 1'b0;
    end else if (put_done) begin
      atom_shadow_reg <= put_atom_reg;
    end else if (accept) begin
      atom_shadow_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // hardware events beat a software write landing in the same cycle
  // a put sitting in an outside delay slot keeps the break flag; only the
  // slot opened by our own return from break ends here
  logic slot_end;
  assign slot_end = (state_reg == S_SLOT && accept && !(is_put && !put_fault)) ||
                    (put_done && put_slot_reg && !in_delay_slot);

  // the software write is applied first so every event below overrides it
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= STATUS_RST;
    end else begin
      if (reg_wr && reg_addr == REG_STATUS) begin
        status_reg <= reg_wdata[ST_W-1:0];
      end
      if (put_done && put_nblk_reg) begin
        status_reg[ST_CARRY] <= !sel_ready;
      end else if (accept && is_rsub && !instr[BIT_KEEP]) begin
        status_reg[ST_CARRY] <= sub_sum[XLEN];
      end
      if (break_enter) begin
        status_reg[ST_BIP] <= 1'b1;
        status_reg[ST_UMS] <= status_reg[ST_UM];
        status_reg[ST_VMS] <= status_reg[ST_VM];
        status_reg[ST_UM]  <= 1'b0;
        status_reg[ST_VM]  <= 1'b0;
      end else if (slot_end) begin
        status_reg[ST_BIP] <= 1'b0;
        status_reg[ST_UM]  <= status_reg[ST_UMS];
        status_reg[ST_VM]  <= status_reg[ST_VMS];
      end
    end
  end

  // ----------------------------------------------------------------
  // results and exceptions
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_write <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_write <= accept && is_rsub;
      if (accept && is_rsub) begin
        rd_data <= sub_sum[XLEN-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      branch_valid  <= 1'b0;
      branch_target <= '0;
    end else begin
      branch_valid <= accept && is_rtbd && !rtb_fault;
      if (accept && is_rtbd) begin
        branch_target <= op_a + imm32;
      end
    end
  end

  // privilege faults; the cause stays readable until the next fault
  always_ff @(posedge clk) begin
    if (reset) begin
      exc_valid <= 1'b0;
      cause_reg <= CAUSE_RST;
    end else begin
      exc_valid <= accept && ((is_put && put_fault) || (is_rtbd && rtb_fault));
      if (accept && ((is_put && put_fault) || (is_rtbd && rtb_fault))) begin
        cause_reg <= EC_PRIV;
      end
    end
  end
  assign exc_cause = cause_reg;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == REG_STATUS) begin
      reg_rdata <= {{(XLEN-ST_W){1'b0}}, status_reg};
    end else if (reg_rd && reg_addr == REG_EXC) begin
      reg_rdata <= {{(XLEN-5){1'b0}}, cause_reg};
    end else begin
      reg_rdata <= '0; // data only in the cycle after the strobe
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // one clock domain, so one default clocking serves every check below
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  link_fold_a: assert property (accept && is_put && !put_fault &&
      int'(op_b[3:0]) >= stream_link_count |=> put_link_reg == '0)
    else $error("out of range link not folded to 0");
  blk_stall_a: assert property (state_reg == S_PUT && !put_nblk_reg && !sel_ready && !put_abort
      |=> state_reg == S_PUT && stall)
    else $error("blocking put left without space");
  nblk_carry_a: assert property (state_reg == S_PUT && put_nblk_reg
      |=> state_reg == S_IDLE && status_reg[ST_CARRY] == !$past(sel_ready))
    else $error("non-blocking put carry wrong");
  last_bit_a: assert property (accept && is_put && !put_fault
      |=> m_axis_tlast[put_link_reg] == $past(instr[BIT_CTRL]))
    else $error("last bit does not follow control bit");
  test_quiet_a: assert property (put_test_reg |-> m_axis_tvalid == '0)
    else $error("test put raised valid");
  atom_irq_a: assert property (put_done && put_atom_reg |=> !irq_allow)
    else $error("interrupt allowed after atomic put");
  priv_put_a: assert property (accept && is_put && put_fault
      |=> exc_valid && exc_cause == EC_PRIV && state_reg != S_PUT)
    else $error("user put not faulted");
  rsub_val_a: assert property (accept && is_rsub
      |=> rd_write && rd_data == $past(sub_b - op_a - XLEN'(!sub_cin)))
    else $error("reverse subtract result wrong");
  keep_carry_a: assert property (accept && is_rsub && instr[BIT_KEEP] &&
      !(reg_wr && reg_addr == REG_STATUS) |=> $stable(status_reg[ST_CARRY]))
    else $error("keep variant changed carry");
  rtb_slot_a: assert property (accept && is_rtbd && !rtb_fault
      |=> branch_valid && state_reg == S_SLOT && !break_allow && !irq_allow)
    else $error("delay slot not protected");
  rtb_priv_a: assert property (accept && is_rtbd && rtb_fault |=> !branch_valid && exc_valid)
    else $error("user return from break branched");
  slot_irq_a: assert property (state_reg == S_PUT && put_slot_reg |-> !irq_take)
    else $error("delay slot put interrupted");
  // the link and the flags that the outside only sees indirectly
  put_yield_a: assert property (put_abort |=> state_reg == S_IDLE && m_axis_tvalid == '0)
    else $error("abandoned put still offered");
  link_idle_a: assert property (state_reg != S_PUT |-> m_axis_tvalid == '0)
    else $error("link strobed outside a put");
  slot_restore_a: assert property (state_reg == S_SLOT && accept && !is_put && !break_enter
      |=> !status_reg[ST_BIP] && status_reg[ST_UM] == $past(status_reg[ST_UMS]) &&
          status_reg[ST_VM] == $past(status_reg[ST_VMS]))
    else $error("break flags not restored after delay slot");
  rsub_borrow_a: assert property (accept && is_rsub && !instr[BIT_KEEP] && !instr[BIT_CUSE]
      |=> status_reg[ST_CARRY] == ($past(sub_b) >= $past(op_a)))
    else $error("carry is not the no-borrow flag");

  put_blocked_c: cover property (state_reg == S_PUT && !sel_ready ##1 put_done);
  put_abort_c:   cover property (put_abort);
  rtb_done_c:    cover property (state_reg == S_SLOT ##1 state_reg == S_IDLE && !status_reg[ST_BIP]);
  rsub_cin_c:    cover property (accept && is_rsub && instr[BIT_CUSE] && !status_reg[ST_CARRY]);
  nblk_full_c:   cover property (put_done && put_nblk_reg && !sel_ready);
endmodule
`default_nettype wire

// >>> testbench/sprb_link_slave.sv
// stream slave model: one ready line per outgoing link
// assumes the bench picks the ready behaviour through ready_mode
`default_nettype none
module sprb_link_slave
  import sprb_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // ready behaviour: 0 always, 1 random, 2 never
  input  wire logic [1:0]          ready_mode,
  // link handshake
  output logic      [LINK_MAX-1:0] tready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready moves only after an edge; random mode stalls at will
  always_ff @(posedge clk) begin
    if (reset) begin
      tready <= '0;
    end else begin
      tready <= (ready_mode == 2'h0) ? '1 : (ready_mode == 2'h1) ? LINK_MAX'($urandom) : '0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/sprb_bench.sv
// self-checking bench for the put / reverse subtract / return from break unit
// assumes sprb_pkg compiled first; the slave model drives every ready line
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %s", $time, m); end end
module stream_put_rsub_break_return_exec_bench
  import sprb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINKS = 12;  // below sixteen so high indices fall back to link 0
  // ----------
  // signals
  // ----------
  logic                          clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_q = 1'h0;
  logic                          instr_valid = 1'h0, imm_prefix_valid = 1'h0, in_delay_slot = 1'h0;
  logic                          break_enter = 1'h0, irq_pending = 1'h0, co, cin, pfx;
  logic [3:0]                    reg_addr = '0, sel;
  logic [XLEN-1:0]               reg_wdata = '0, instr = '0, op_a = '0, op_b = '0, a, b, i, opnd, r;
  logic [XLEN-1:0]               reg_rdata, rd_data, branch_target, q_rd[$], q_br[$], q_reg[$];
  logic [15:0]                   imm_prefix_hi = '0, hi;
  logic [1:0]                    ready_mode = 2'h0;
  logic                          stall, rd_write, branch_valid, exc_valid, irq_take, irq_allow, break_allow;
  logic [4:0]                    exc_cause, cause = CAUSE_RST, q_exc[$];
  logic [LINK_MAX-1:0][XLEN-1:0] m_axis_tdata;
  logic [LINK_MAX-1:0]           m_axis_tlast, m_axis_tvalid, m_axis_tready;
  logic [36:0]                   q_put[$];
  logic [5:0]                    st = STATUS_RST;
  int                            n_fail = 0, total_checks = 0, n_irq = 0, v;
  sprb_exec #(.stream_link_count(LINKS), .mmu_level(1), .allow_user_stream_ops(0),
              .extended_stream_ops_enable(1)) dut (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_valid, .instr, .op_a, .op_b,
    .imm_prefix_valid, .imm_prefix_hi, .in_delay_slot, .break_enter, .stall, .rd_write, .rd_data,
    .branch_valid, .branch_target, .exc_valid, .exc_cause, .irq_pending, .irq_take, .irq_allow,
    .break_allow, .m_axis_tdata, .m_axis_tlast, .m_axis_tvalid, .m_axis_tready);
  sprb_link_slave slave (.clk, .reset, .ready_mode, .tready(m_axis_tready));
  always #25 clk = ~clk;
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= reg_rd;
  // monitor: an empty queue yields x so an unexpected result never matches
  always @(negedge clk) begin
    if (rd_write === 1'h1) begin
      if (q_rd.size() == 0) q_rd.push_back('x);
      `CHK(rd_data, q_rd.pop_front(), "rsub result")
    end
    if (branch_valid === 1'h1) begin
      if (q_br.size() == 0) q_br.push_back('x);
      `CHK(branch_target, q_br.pop_front(), "branch target")
    end
    if (exc_valid === 1'h1) begin
      if (q_exc.size() == 0) q_exc.push_back('x);
      `CHK(exc_cause, q_exc.pop_front(), "fault cause")
    end
    if (rd_q === 1'h1) begin
      if (q_reg.size() == 0) q_reg.push_back('x);
      `CHK(reg_rdata, q_reg.pop_front(), "register read")
    end
    for (int l = 0; l < LINK_MAX; l++) begin
      if (m_axis_tvalid[l] === 1'h1 && m_axis_tready[l] === 1'h1) begin
        if (q_put.size() == 0) q_put.push_back('x);
        `CHK({4'(l), m_axis_tlast[l], m_axis_tdata[l]}, q_put.pop_front(), "stream beat")
      end
    end
    if (irq_take === 1'h1) n_irq++;
  end
  // ----------
  // tasks
  // ----------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one-cycle register access; a read notes what the next cycle must show
  task automatic reg_op(input logic w, input logic [3:0] ad, input logic [XLEN-1:0] d);
    if (!w) q_reg.push_back(ad == REG_STATUS ? XLEN'(st) : ad == REG_EXC ? XLEN'(cause) : '0);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {ad, d, w, !w};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
  endtask
  // offer one instruction; a put is held until the edge that ends it
  task automatic issue(input logic [XLEN-1:0] w, x, y, input logic put, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {instr_valid, instr, op_a, op_b} <= {1'h1, w, x, y};
    @(posedge clk);
    if (put) begin
      do begin
        @(negedge clk);
        n++;
      end while (n < 200 && !(stall === 1'h1 && (w[BIT_NBLK] || m_axis_tready[s] || irq_take === 1'h1)));
      if (n >= 200) begin
        n_fail++;
        $display("wrong value at %0t: put never ended", $time);
        give_verdict();
      end
      if (w[BIT_NBLK]) `CHK(n, 1, "non-blocking length")
      @(posedge clk);
    end
    instr_valid <= 1'h0;
    if (put) begin
      @(negedge clk);
      `CHK(stall, 1'h0, "stall after put")
      @(posedge clk);
    end
  endtask
  function automatic logic [XLEN-1:0] put_word(input logic [3:0] pv);
    put_word = {OP_PUTD, 26'h0};
    put_word[BIT_PUT_ONE] = 1'h1;
    {put_word[BIT_NBLK], put_word[BIT_CTRL], put_word[BIT_TEST], put_word[BIT_ATOM]} = pv;
  endfunction
  // pv holds non-blocking, control, test, atomic from high to low
  task automatic do_put(input logic [3:0] pv, input logic [1:0] mode, input logic beat);
    a = $urandom;
    b = $urandom;
    sel = (b[3:0] < LINKS) ? b[3:0] : 4'h0;
    ready_mode <= mode;
    if (beat && !pv[1] && mode != 2'h2) q_put.push_back({sel, pv[2], a});
    if (pv[3]) st[ST_CARRY] = (mode == 2'h2);
    issue(put_word(pv), a, b, 1'h1, sel);
    if (pv[3]) reg_op(1'h0, REG_STATUS, '0);
  endtask
  // reverse subtract; the first two loop passes hit no-borrow and borrow
  task automatic do_rsub(input logic k, c, imm);
    b = $urandom;
    a = (!imm && v < 2) ? b + XLEN'(v) : XLEN'($urandom);
    i = {imm ? OP_RSUBI : OP_RSUB, k, c, 1'h1, 10'($urandom), imm ? 16'($urandom) : 16'h0};
    pfx = imm & 1'($urandom);
    hi = $urandom;
    {imm_prefix_valid, imm_prefix_hi} <= {pfx, hi};
    opnd = !imm ? b : pfx ? {hi, i[15:0]} : {{16{i[15]}}, i[15:0]};
    cin = c ? st[ST_CARRY] : 1'h1;
    {co, r} = {1'h0, opnd} + {1'h0, ~a} + 33'(cin);
    q_rd.push_back(r);
    if (!k) st[ST_CARRY] = co;
    issue(i, a, b, 1'h0, 4'h0);
    imm_prefix_valid <= 1'h0;
    reg_op(1'h0, REG_STATUS, '0);
  endtask
  initial begin
    void'($urandom(32'h5F6258DA));
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    // reset values, an unmapped place, a write read back
    reg_op(1'h0, REG_STATUS, '0);
    reg_op(1'h0, REG_EXC, '0);
    reg_op(1'h0, 4'h8, '0);
    st = 6'h01;
    reg_op(1'h1, REG_STATUS, XLEN'(st));
    reg_op(1'h0, REG_STATUS, '0);
    $display("test registers done");
    // all sixteen put variants; non-blocking ones face full and empty links
    for (v = 0; v < 16; v++) do_put(4'(v), v[3] ? {v[0], 1'h0} : 2'h1, 1'h1);
    $display("test puts done");
    for (v = 0; v < 24; v++) do_rsub(v[2], v[3], v[1]);
    $display("test reverse subtract done");
    // user mode faults, then break entry and return with a delay slot
    st = st | 6'h0A;
    reg_op(1'h1, REG_STATUS, XLEN'(st));
    q_exc.push_back(EC_PRIV);
    cause = EC_PRIV;
    issue(put_word(4'h0), $urandom, $urandom, 1'h0, 4'h0);
    q_exc.push_back(EC_PRIV);
    issue({OP_RTBD, RTBD_SEL, 21'($urandom)}, $urandom, $urandom, 1'h0, 4'h0);
    reg_op(1'h0, REG_EXC, '0);
    break_enter <= 1'h1;
    @(posedge clk);
    break_enter <= 1'h0;
    a = $urandom;
    i = {OP_RTBD, RTBD_SEL, 5'h10, 16'($urandom)};
    q_br.push_back(a + {{16{i[15]}}, i[15:0]});
    issue(i, a, '0, 1'h0, 4'h0);
    @(negedge clk);
    `CHK({irq_allow, break_allow}, 2'h0, "delay slot gating")
    @(posedge clk);
    st = {1'h0, 1'h1, 1'h1, 1'h1, 1'h1, st[ST_CARRY]};
    do_rsub(1'h1, 1'h0, 1'h0);
    st = st & 6'h01;
    reg_op(1'h1, REG_STATUS, XLEN'(st));
    $display("test return from break done");
    // interrupt abort, atomic shield and delay-slot put
    irq_pending <= 1'h1;
    do_put(4'h0, 2'h2, 1'h0);
    `CHK(n_irq, 1, "interrupt in stall")
    do_put(4'h1, 2'h1, 1'h1);
    @(negedge clk);
    `CHK(irq_allow, 1'h0, "atomic shadow")
    @(posedge clk);
    do_rsub(1'h1, 1'h0, 1'h0);
    in_delay_slot <= 1'h1;
    do_put(4'h0, 2'h1, 1'h1);
    `CHK(n_irq, 1, "no interrupt taken")
    {in_delay_slot, irq_pending} <= 2'h0;
    $display("test interrupts done");
    give_verdict();
  end
endmodule
`default_nettype wire
